// *** core/alau_consts.vh ***
// Constants for the accumulator logic and arithmetic unit
`ifndef ALAU_CONSTS_VH
`define ALAU_CONSTS_VH
// Operation select codes
`define ALAU_OP_NOP        5'h00
`define ALAU_OP_AND        5'h01
`define ALAU_OP_XOR        5'h02
`define ALAU_OP_LOGIC      5'h03
`define ALAU_OP_ADD        5'h04
`define ALAU_OP_SUB        5'h05
`define ALAU_OP_NEG        5'h06
`define ALAU_OP_INC1       5'h07
`define ALAU_OP_INC2       5'h08
`define ALAU_OP_DEC1       5'h09
`define ALAU_OP_DEC2       5'h0A
`define ALAU_OP_ADDC       5'h0B
`define ALAU_OP_SSP        5'h0C
`define ALAU_OP_SSM        5'h0D
`define ALAU_OP_CHS        5'h0E
`define ALAU_OP_CPYS       5'h0F
`define ALAU_OP_DBL        5'h10
`define ALAU_OP_SGL        5'h11
`define ALAU_OP_NORM       5'h12
`define ALAU_OP_LDSC       5'h13
`define ALAU_OP_RDKEY      5'h14
`define ALAU_OP_WRKEY      5'h15
`define ALAU_OP_LOAD       5'h16
`define ALAU_OP_STORE      5'h17
`define ALAU_OP_MPY        5'h18
`define ALAU_OP_DIV        5'h19
`define ALAU_OP_PIM        5'h1A
`define ALAU_OP_PID        5'h1B
// Logicize condition codes
`define ALAU_C_LT          3'h0
`define ALAU_C_LE          3'h1
`define ALAU_C_NE          3'h2
`define ALAU_C_EQ          3'h3
`define ALAU_C_GE          3'h4
`define ALAU_C_GT          3'h5
`define ALAU_C_FALSE       3'h6
`define ALAU_C_TRUE        3'h7
// Word constants
`define ALAU_ZERO          16'h0000
`define ALAU_ONE           16'h0001
`define ALAU_TWO           16'h0002
`define ALAU_MAXPOS        16'h7FFF
`define ALAU_MAXPOS_M1     16'h7FFE
`define ALAU_MAXNEG        16'h8000
`define ALAU_MAXNEG_P1     16'h8001
`define ALAU_SIGN_BIT      15
`define ALAU_LOW_HALF      7:0
`define ALAU_ZERO_BYTE     8'h00
// Key word layout (bit 1 is the msb, index 15)
`define ALAU_KEY_C         15
`define ALAU_KEY_DBL       14
`define ALAU_KEY_MODE      11:10
`define ALAU_MODE_RESET    2'h0
`define ALAU_SCNT_RESET    8'h00
`define ALAU_TRAP_VECTOR   16'h0036
`define ALAU_SCNT_ADDR     16'h0006
`define ALAU_CNT_ZERO      5'h00
`define ALAU_CNT_ONE       5'h01
`define ALAU_CNT_MAX       5'h1E
`endif

// *** core/alau_core.v ***
// Accumulator datapath: logic, single-length arithmetic, signs, modes, normalize, keys
//
// Contract
// - AND memory word into accumulator
// - XOR memory word into accumulator
// - Logicize: true gives one, else zero
// - Condition codes 0-5 compare against zero
// - Codes 6,7 force false or true
// - Add sets carry on signed overflow
// - Subtract sets carry on signed overflow
// - Negate; most negative overflows, sets carry
// - Increment one; max positive wraps, carry
// - Increment two; top two wrap, carry
// - Decrement one; most negative wraps, carry
// - Decrement two; bottom two wrap, carry
// - Add carry bit as accumulator lsb
// - Set minus forces, change sign inverts
// - Copy sign into carry, clear sign
// - Reset selects single; double uses extension
// - Enter double and single select mode
// - No option: trap on double ops, multiply
// - Normalize shifts pair, count to location six
// - Load shift count into low byte
// - Key word layout: carry, double, mode
// - Key low byte mirrors location six
// - Read keys loads accumulator
// - Write keys sets modes, location six
`timescale 1ns/1ps
`include "alau_consts.vh"

module alau_core
(
   input  wire        clk_in,          // CPU clock, 250 MHz
   input  wire        sys_rst_in,      // Synchronous reset, master clear
   input  wire        op_valid_in,     // One-cycle operation strobe
   input  wire [4:0]  op_code_in,      // Operation select
   input  wire [2:0]  cond_in,         // Logicize condition, instruction bits 14-16
   input  wire [15:0] mem_data_in,     // Operand word at effective_address
   input  wire [15:0] mem_data_lo_in,  // Second operand word in double mode
   input  wire        dbl_option_in,   // Double precision hardware present
   output reg  [15:0] acc_out,         // Accumulator
   output reg  [15:0] ext_out,         // Extension register
   output reg         carry_out,       // Carry/overflow bit
   output reg         dbl_mode_out,    // Double precision selected
   output reg  [1:0]  addr_mode_out,   // Addressing mode key
   output reg  [15:0] key_word_out,    // machine_key_word, registered one cycle behind its fields
   output reg  [7:0]  shift_cnt_out,   // Low byte of location six
   output reg         mem_wr_out,      // Store strobe, one cycle
   output reg  [15:0] mem_wr_addr_out, // Store address, zero means effective_address
   output reg  [15:0] mem_wr_data_out, // Store data, high word
   output reg  [15:0] mem_wr_data_lo_out, // Store data, low word in double mode
   output reg         mem_wr_dbl_out,  // Store is double length
   output reg         trap_out,        // unimplemented_instruction_trap pulse
   output reg  [15:0] trap_vector_out, // Trap vector location
   output reg         busy_out,        // Normalize in progress
   output reg         done_out         // Operation finished pulse
);

   // Normalize state machine, one-hot
   localparam [1:0] ST_IDLE  = 2'b01;
   localparam [1:0] ST_NORM  = 2'b10;

   reg  [1:0]  state;          // Current state
   reg  [4:0]  norm_cnt;       // Shifts performed so far
   // Results below apply only when an operation is taken
   reg  [15:0] next_acc;       // Combinational accumulator result
   reg  [15:0] next_ext;       // Combinational extension result
   reg         next_carry;     // Combinational carry result
   reg         truth;          // Logicize condition outcome
   reg  [16:0] sum_wide;       // Add or subtract with extra bit
   wire [15:0] key_word;       // Assembled key word
   wire        is_neg;         // Accumulator sign
   wire        is_zero;        // Accumulator zero
   wire        dbl_op;         // Mode-dependent memory reference
   wire        needs_trap;     // Missing option request
   wire        norm_stop;      // Bit 2 differs from sign

   // Sign and zero flags feed the logicize tests
   assign is_neg  = acc_out[`ALAU_SIGN_BIT];
   assign is_zero = (acc_out == `ALAU_ZERO);

   // Key word: carry, double, reserved, mode, reserved, shift count
   assign key_word = {carry_out, dbl_mode_out, 2'h0, addr_mode_out, 2'h0, shift_cnt_out};

   // References that grow to two words in double mode
   assign dbl_op = (op_code_in == `ALAU_OP_ADD) || (op_code_in == `ALAU_OP_SUB) ||
                   (op_code_in == `ALAU_OP_LOAD) || (op_code_in == `ALAU_OP_STORE);

   // Trap when the option is missing; multiply group always traps then
   // A trapping op changes no register, so emulation starts clean
   assign needs_trap = !dbl_option_in &&
                       ((dbl_mode_out && dbl_op) ||
                        (op_code_in == `ALAU_OP_MPY) || (op_code_in == `ALAU_OP_DIV) ||
                        (op_code_in == `ALAU_OP_PIM) || (op_code_in == `ALAU_OP_PID));

   // Normalize ends once bit 2 is opposite the sign bit
   // Cap bounds an all-zero pair, which would never stop
   assign norm_stop = (acc_out[14] != acc_out[15]) || (norm_cnt == `ALAU_CNT_MAX);

   // Logicize condition decode
   // Codes 6 and 7 ignore the accumulator
   always @*
   begin
      case (cond_in)
         `ALAU_C_LT:    truth = is_neg;
         `ALAU_C_LE:    truth = is_neg || is_zero;
         `ALAU_C_NE:    truth = !is_zero;
         `ALAU_C_EQ:    truth = is_zero;
         `ALAU_C_GE:    truth = !is_neg;
         `ALAU_C_GT:    truth = !is_neg && !is_zero;
         `ALAU_C_FALSE: truth = 1'b0;
         default:       truth = 1'b1;
      endcase
   end

   // Single-cycle datapath result
   always @*
   begin
      next_acc   = acc_out;
      next_ext   = ext_out;
      next_carry = carry_out;
      sum_wide   = 17'h00000;
      // Defaults hold state, so unlisted codes change nothing
      case (op_code_in)
         `ALAU_OP_AND:
            next_acc = acc_out & mem_data_in;
         `ALAU_OP_XOR:
            next_acc = acc_out ^ mem_data_in;
         `ALAU_OP_LOGIC:
            next_acc = truth ? `ALAU_ONE : `ALAU_ZERO;
         `ALAU_OP_ADD:
         begin
            if (dbl_mode_out)
            begin
               // Double length: extension is low word, bit 1 of low words bypassed
               sum_wide = {2'h0, ext_out[14:0]} + {2'h0, mem_data_lo_in[14:0]};
               next_ext = {1'b0, sum_wide[14:0]};
               next_acc = acc_out + mem_data_in + {15'h0000, sum_wide[15]};
               next_carry = (acc_out[15] == mem_data_in[15]) && (next_acc[15] != acc_out[15]);
            end
            else
            begin
               // Same input signs, result sign differs: overflow
               next_acc = acc_out + mem_data_in;
               next_carry = (acc_out[15] == mem_data_in[15]) && (next_acc[15] != acc_out[15]);
            end
         end
         `ALAU_OP_SUB:
         begin
            if (dbl_mode_out)
            begin
               // Borrow from low word propagates into the high word
               sum_wide = {2'h0, ext_out[14:0]} - {2'h0, mem_data_lo_in[14:0]};
               next_ext = {1'b0, sum_wide[14:0]};
               next_acc = acc_out - mem_data_in - {15'h0000, sum_wide[15]};
               next_carry = (acc_out[15] != mem_data_in[15]) && (next_acc[15] != acc_out[15]);
            end
            else
            begin
               // Input signs differ, result leaves minuend sign
               next_acc = acc_out - mem_data_in;
               next_carry = (acc_out[15] != mem_data_in[15]) && (next_acc[15] != acc_out[15]);
            end
         end
         `ALAU_OP_LOAD:
         begin
            // Low word taken only in double mode
            next_acc = mem_data_in;
            if (dbl_mode_out)
               next_ext = mem_data_lo_in;
         end
         `ALAU_OP_NEG:
         begin
            // Most negative value negates to itself
            next_acc   = `ALAU_ZERO - acc_out;
            next_carry = (acc_out == `ALAU_MAXNEG);
         end
         `ALAU_OP_INC1:
         begin
            next_acc   = acc_out + `ALAU_ONE;
            next_carry = (acc_out == `ALAU_MAXPOS);
         end
         `ALAU_OP_INC2:
         begin
            // Two largest positives wrap
            next_acc   = acc_out + `ALAU_TWO;
            next_carry = (acc_out == `ALAU_MAXPOS) || (acc_out == `ALAU_MAXPOS_M1);
         end
         `ALAU_OP_DEC1:
         begin
            next_acc   = acc_out - `ALAU_ONE;
            next_carry = (acc_out == `ALAU_MAXNEG);
         end
         `ALAU_OP_DEC2:
         begin
            next_acc   = acc_out - `ALAU_TWO;
            next_carry = (acc_out == `ALAU_MAXNEG) || (acc_out == `ALAU_MAXNEG_P1);
         end
         `ALAU_OP_ADDC:
         begin
            // Only a set carry can push past the maximum
            next_acc   = acc_out + {15'h0000, carry_out};
            next_carry = carry_out && (acc_out == `ALAU_MAXPOS);
         end
         `ALAU_OP_SSP:
            next_acc = {1'b0, acc_out[14:0]};
         `ALAU_OP_SSM:
            next_acc = {1'b1, acc_out[14:0]};
         `ALAU_OP_CHS:
            next_acc = {!acc_out[15], acc_out[14:0]};
         `ALAU_OP_CPYS:
         begin
            // Old sign goes to carry before it is cleared
            next_carry = acc_out[15];
            next_acc   = {1'b0, acc_out[14:0]};
         end
         `ALAU_OP_LDSC:
            next_acc = {`ALAU_ZERO_BYTE, shift_cnt_out};
         `ALAU_OP_RDKEY:
            next_acc = key_word;
         `ALAU_OP_WRKEY:
            // Modes and count are loaded in the clocked block
            next_carry = acc_out[`ALAU_KEY_C];
         default:
         begin
            next_acc   = acc_out;
            next_carry = carry_out;
         end
      endcase
   end

   // Register update and normalize sequencing
   always @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         state              <= ST_IDLE;
         norm_cnt           <= `ALAU_CNT_ZERO;
         acc_out            <= `ALAU_ZERO;
         ext_out            <= `ALAU_ZERO;
         carry_out          <= 1'b0;
         dbl_mode_out       <= 1'b0;
         addr_mode_out      <= `ALAU_MODE_RESET;
         key_word_out       <= `ALAU_ZERO;
         shift_cnt_out      <= `ALAU_SCNT_RESET;
         mem_wr_out         <= 1'b0;
         mem_wr_addr_out    <= `ALAU_ZERO;
         mem_wr_data_out    <= `ALAU_ZERO;
         mem_wr_data_lo_out <= `ALAU_ZERO;
         mem_wr_dbl_out     <= 1'b0;
         trap_out           <= 1'b0;
         trap_vector_out    <= `ALAU_TRAP_VECTOR;
         busy_out           <= 1'b0;
         done_out           <= 1'b0;
      end
      else
      begin
         // Pulses default low
         mem_wr_out   <= 1'b0;
         trap_out     <= 1'b0;
         done_out     <= 1'b0;
         // Key word copy lags one cycle behind its fields
         key_word_out <= key_word;
         case (state)
            ST_IDLE:
            begin
               // New strobes only start from idle; busy ignores them
               if (op_valid_in)
               begin
                  if (needs_trap)
                  begin
                     // Nothing changes; software emulation takes over
                     trap_out <= 1'b1;
                     done_out <= 1'b1;
                  end
                  else if (op_code_in == `ALAU_OP_NORM)
                  begin
                     state    <= ST_NORM;
                     norm_cnt <= `ALAU_CNT_ZERO;
                     busy_out <= 1'b1;
                  end
                  else
                  begin
                     acc_out   <= next_acc;
                     ext_out   <= next_ext;
                     carry_out <= next_carry;
                     done_out  <= 1'b1;
                     if (op_code_in == `ALAU_OP_DBL)
                        dbl_mode_out <= 1'b1;
                     if (op_code_in == `ALAU_OP_SGL)
                        dbl_mode_out <= 1'b0;
                     if (op_code_in == `ALAU_OP_WRKEY)
                     begin
                        // Modes from bits 2 and 5-6; count from low byte
                        dbl_mode_out  <= acc_out[`ALAU_KEY_DBL];
                        addr_mode_out <= acc_out[`ALAU_KEY_MODE];
                        shift_cnt_out <= acc_out[`ALAU_LOW_HALF];
                        mem_wr_out      <= 1'b1;
                        mem_wr_addr_out <= `ALAU_SCNT_ADDR;
                        mem_wr_data_out <= {`ALAU_ZERO_BYTE, acc_out[`ALAU_LOW_HALF]};
                        mem_wr_dbl_out  <= 1'b0;
                     end
                     // Address zero tells memory to use effective_address
                     if (op_code_in == `ALAU_OP_STORE)
                     begin
                        mem_wr_out         <= 1'b1;
                        mem_wr_addr_out    <= `ALAU_ZERO;
                        mem_wr_data_out    <= acc_out;
                        mem_wr_data_lo_out <= ext_out;
                        mem_wr_dbl_out     <= dbl_mode_out;
                     end
                  end
               end
            end
            ST_NORM:
            begin
               if (norm_stop)
               begin
                  // Count goes to location six and its mirror
                  state           <= ST_IDLE;
                  busy_out        <= 1'b0;
                  done_out        <= 1'b1;
                  shift_cnt_out   <= {3'h0, norm_cnt};
                  mem_wr_out      <= 1'b1;
                  mem_wr_addr_out <= `ALAU_SCNT_ADDR;
                  mem_wr_data_out <= {11'h000, norm_cnt};
                  mem_wr_dbl_out  <= 1'b0;
               end
               else
               begin
                  // Sign kept, bit 2 dropped, extension bit 1 bypassed
                  acc_out  <= {acc_out[15], acc_out[13:0], ext_out[14]};
                  ext_out  <= {ext_out[15], ext_out[13:0], 1'b0};
                  norm_cnt <= norm_cnt + `ALAU_CNT_ONE;
               end
            end
            default:
               // Unused code falls back to idle
               state <= ST_IDLE;
         endcase
      end
   end

endmodule // alau_core

// *** testbench/alau_core_assertions.sv ***
// Concurrent checks on the accumulator unit ports
`timescale 1ns/1ps
`include "alau_consts.vh"

module alau_core_assertions
(
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        op_valid_in,
   input wire logic [4:0]  op_code_in,
   input wire logic [15:0] mem_data_in,
   input wire logic        dbl_option_in,
   input wire logic [15:0] acc_out,
   input wire logic        carry_out,
   input wire logic        dbl_mode_out,
   input wire logic [15:0] key_word_out,
   input wire logic [7:0]  shift_cnt_out,
   input wire logic        mem_wr_out,
   input wire logic [15:0] mem_wr_addr_out,
   input wire logic [15:0] mem_wr_data_out,
   input wire logic        trap_out,
   input wire logic [15:0] trap_vector_out,
   input wire logic        busy_out,
   input wire logic        done_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // An operation is only taken while idle
   wire take = op_valid_in && !busy_out;
   // Normalize steps: accepted, then finished with the count stored
   sequence norm_take;
      take && op_code_in == `ALAU_OP_NORM;
   endsequence
   sequence norm_end;
      done_out && !busy_out && mem_wr_out && mem_wr_addr_out == 16'h0006
         && shift_cnt_out == mem_wr_data_out[7:0];
   endsequence
   and_result_a: assert property (take && op_code_in == `ALAU_OP_AND |=>
      acc_out == ($past(acc_out) & $past(mem_data_in))) else $error("and result wrong");
   xor_result_a: assert property (take && op_code_in == `ALAU_OP_XOR |=>
      acc_out == ($past(acc_out) ^ $past(mem_data_in))) else $error("xor result wrong");
   neg_result_a: assert property (take && op_code_in == `ALAU_OP_NEG |=>
      acc_out == 16'h0000 - $past(acc_out) && carry_out == ($past(acc_out) == 16'h8000))
      else $error("negate result wrong");
   // Reset must leave single precision, so no disable here
   reset_single_a: assert property (@(posedge clk_in) disable iff (1'b0)
      sys_rst_in |=> !dbl_mode_out) else $error("reset left double mode");
   dbl_enter_a: assert property (take && op_code_in == `ALAU_OP_DBL |=>
      dbl_mode_out ##1 key_word_out[14]) else $error("double mode not entered");
   trap_raise_a: assert property (take && !dbl_option_in && op_code_in == `ALAU_OP_MPY |=>
      trap_out && done_out && trap_vector_out == 16'h0036) else $error("no trap on multiply");
   norm_count_a: assert property (norm_take |-> ##[1:33] norm_end)
      else $error("normalize did not finish");
   load_count_a: assert property (take && op_code_in == `ALAU_OP_LDSC |=>
      acc_out == {8'h00, $past(shift_cnt_out)}) else $error("shift count load wrong");
endmodule // alau_core_assertions

bind alau_core alau_core_assertions alau_core_assertions_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .op_valid_in(op_valid_in), .op_code_in(op_code_in), .mem_data_in(mem_data_in), .dbl_option_in(dbl_option_in),
   .acc_out(acc_out), .carry_out(carry_out), .dbl_mode_out(dbl_mode_out), .key_word_out(key_word_out),
   .shift_cnt_out(shift_cnt_out), .mem_wr_out(mem_wr_out), .mem_wr_addr_out(mem_wr_addr_out),
   .mem_wr_data_out(mem_wr_data_out), .trap_out(trap_out), .trap_vector_out(trap_vector_out),
   .busy_out(busy_out), .done_out(done_out));

// *** testbench/alau_mem_model.sv ***
// Main memory model supplying operands at the effective address
`timescale 1ns/1ps

module alau_mem_model
(
   input  wire logic        clk_in,
   input  wire logic [15:0] ea_in,        // effective_address
   input  wire logic        wr_in,        // Store strobe
   input  wire logic [15:0] wr_addr_in,   // Zero means effective_address
   input  wire logic [15:0] wr_data_in,   // Store word
   output wire logic [15:0] data_out,     // Operand word
   output wire logic [15:0] data_lo_out   // Next word, low half of a pair
);
   logic [15:0] words [0:15];             // Small image, address wraps at 16
   // Read is combinational, the unit samples it with the strobe
   assign data_out    = words[ea_in[3:0]];
   assign data_lo_out = words[ea_in[3:0] + 4'h1];
   // Stores land on the clock edge that carries the strobe
   always @(posedge clk_in)
      if (wr_in)
         words[(wr_addr_in == 16'h0000) ? ea_in[3:0] : wr_addr_in[3:0]] <= wr_data_in;
endmodule // alau_mem_model

// *** testbench/alau_core_tb.sv ***
// Self-checking bench for the accumulator unit
`timescale 1ns/1ps
`include "alau_consts.vh"
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin miscompares++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end

module alau_core_tb;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, op_valid_in = 1'b0, dbl_option_in = 1'b1;
   logic [4:0]  op_code_in = 5'h00;
   logic [2:0]  cond_in = 3'h0;
   logic [15:0] ea = 16'h0001, mem_d, mem_lo, acc, ext, kw, wa, wd, wdl, tv;
   logic [7:0]  sc;
   logic [1:0]  am;
   logic        cy, dm, mw, mwd, trp, busy, done, exp_c = 1'b0;
   logic [31:0] seed = 32'h0000BD1E;
   logic [16:0] ex;
   int          miscompares = 0, tests_run = 0, cycles = 0;
   logic [4:0]  ops [0:14] = '{`ALAU_OP_AND, `ALAU_OP_XOR, `ALAU_OP_LOGIC, `ALAU_OP_ADD, `ALAU_OP_SUB,
      `ALAU_OP_NEG, `ALAU_OP_INC1, `ALAU_OP_INC2, `ALAU_OP_DEC1, `ALAU_OP_DEC2, `ALAU_OP_ADDC,
      `ALAU_OP_SSP, `ALAU_OP_SSM, `ALAU_OP_CHS, `ALAU_OP_CPYS};
   logic [15:0] corners [0:4] = '{16'h7FFF, 16'h7FFE, 16'h8000, 16'h8001, 16'h0000};

   alau_core alau_core_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .op_valid_in(op_valid_in),
      .op_code_in(op_code_in), .cond_in(cond_in), .mem_data_in(mem_d), .mem_data_lo_in(mem_lo),
      .dbl_option_in(dbl_option_in), .acc_out(acc), .ext_out(ext), .carry_out(cy), .dbl_mode_out(dm),
      .addr_mode_out(am), .key_word_out(kw), .shift_cnt_out(sc), .mem_wr_out(mw), .mem_wr_addr_out(wa),
      .mem_wr_data_out(wd), .mem_wr_data_lo_out(wdl), .mem_wr_dbl_out(mwd), .trap_out(trp),
      .trap_vector_out(tv), .busy_out(busy), .done_out(done));
   alau_mem_model alau_mem_model_inst (.clk_in(clk_in), .ea_in(ea), .wr_in(mw), .wr_addr_in(wa),
      .wr_data_in(wd), .data_out(mem_d), .data_lo_out(mem_lo));

   // 250 MHz clock
   initial forever #2 clk_in = ~clk_in;
   // Hang guard, well above the roughly 1100 cycles the run needs
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin miscompares++; test_done(); end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13; s ^= s >> 17; s ^= s << 5;
      return s;
   endfunction
   // Expected {carry, accumulator} after one single-length operation
   function automatic logic [16:0] ref_op(input logic [4:0] op, input logic [2:0] c,
      input logic [15:0] a, input logic [15:0] m, input logic ci);
      logic [15:0] r; logic co; logic t;
      r = a; co = ci;
      case (op)
         `ALAU_OP_AND:   r = a & m;
         `ALAU_OP_XOR:   r = a ^ m;
         `ALAU_OP_LOGIC:
         begin
            case (c)
               3'h0: t = a[15];
               3'h1: t = a[15] || a == 16'h0000;
               3'h2: t = a != 16'h0000;
               3'h3: t = a == 16'h0000;
               3'h4: t = !a[15];
               3'h5: t = !a[15] && a != 16'h0000;
               3'h6: t = 1'b0;
               default: t = 1'b1;
            endcase
            r = {15'h0000, t};
         end
         `ALAU_OP_ADD:  begin r = a + m; co = a[15] == m[15] && r[15] != a[15]; end
         `ALAU_OP_SUB:  begin r = a - m; co = a[15] != m[15] && r[15] != a[15]; end
         `ALAU_OP_NEG:  begin r = 16'h0000 - a; co = a == 16'h8000; end
         `ALAU_OP_INC1: begin r = a + 16'h0001; co = a == 16'h7FFF; end
         `ALAU_OP_INC2: begin r = a + 16'h0002; co = a[15:1] == 15'h3FFF; end
         `ALAU_OP_DEC1: begin r = a - 16'h0001; co = a == 16'h8000; end
         `ALAU_OP_DEC2: begin r = a - 16'h0002; co = a[15:1] == 15'h4000; end
         `ALAU_OP_ADDC: begin r = a + {15'h0000, ci}; co = ci && a == 16'h7FFF; end
         `ALAU_OP_SSP:  r = {1'b0, a[14:0]};
         `ALAU_OP_SSM:  r = {1'b1, a[14:0]};
         `ALAU_OP_CHS:  r = {~a[15], a[14:0]};
         default:       begin co = a[15]; r = {1'b0, a[14:0]}; end
      endcase
      return {co, r};
   endfunction

   // One strobe at a falling edge, then wait for completion
   task automatic run_op(input logic [4:0] op, input logic [2:0] c);
      int n;
      @(negedge clk_in);
      op_code_in = op; cond_in = c; op_valid_in = 1'b1;
      @(negedge clk_in);
      op_valid_in = 1'b0; n = 0;
      while (done !== 1'b1 && n < 40) begin @(negedge clk_in); n++; end
      `CHK("done", 1'b1, done)
   endtask
   task automatic load(input logic [15:0] v);
      alau_mem_model_inst.words[1] = v; ea = 16'h0001;
      run_op(`ALAU_OP_LOAD, 3'h0);
   endtask
   task automatic check_op(input logic [4:0] op, input logic [2:0] c, input logic [15:0] a, input logic [15:0] m);
      load(a);
      alau_mem_model_inst.words[1] = m;
      run_op(op, c);
      ex = ref_op(op, c, a, m, exp_c);
      `CHK("acc", ex[15:0], acc)
      `CHK("carry", ex[16], cy)
      exp_c = ex[16];
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (8) @(negedge clk_in);
      sys_rst_in = 1'b0;
      `CHK("mode", 1'b0, dm)
      run_op(`ALAU_OP_DBL, 3'h0);
      @(negedge clk_in);
      `CHK("mode", 1'b1, dm)
      `CHK("keydbl", 1'b1, kw[14])
      dbl_option_in = 1'b0;
      run_op(`ALAU_OP_ADD, 3'h0);
      `CHK("trap", 1'b1, trp)
      run_op(`ALAU_OP_SGL, 3'h0);
      `CHK("mode", 1'b0, dm)
      run_op(`ALAU_OP_MPY, 3'h0);
      `CHK("trap", 1'b1, trp)
      dbl_option_in = 1'b1;
      $display("modes test done");
      load(16'h0003);
      run_op(`ALAU_OP_NORM, 3'h0);
      `CHK("normwr", 1'b1, mw)
      `CHK("normaddr", 16'h0006, wa)
      `CHK("normcnt", 16'h000D, wd)
      `CHK("normsc", 8'h0D, sc)
      run_op(`ALAU_OP_LDSC, 3'h0);
      `CHK("ldsc", 16'h000D, acc)
      run_op(`ALAU_OP_RDKEY, 3'h0);
      `CHK("rdkey", {exp_c, 15'h000D}, acc & 16'hCCFF)
      load(16'hC4A5);
      run_op(`ALAU_OP_WRKEY, 3'h0);
      `CHK("wkc", 1'b1, cy)
      `CHK("wkdbl", 1'b1, dm)
      `CHK("wkmode", 2'h1, am)
      `CHK("wkloc6", 16'h00A5, wd)
      run_op(`ALAU_OP_RDKEY, 3'h0);
      `CHK("rdkey", 16'hC4A5, acc & 16'hCCFF)
      // Master clear while in double mode must return to single
      @(negedge clk_in);
      sys_rst_in = 1'b1;
      repeat (2) @(negedge clk_in);
      sys_rst_in = 1'b0;
      `CHK("rstmode", 1'b0, dm)
      exp_c = 1'b0;
      // Double add: low halves carry into the high word
      run_op(`ALAU_OP_DBL, 3'h0);
      alau_mem_model_inst.words[2] = 16'h4001;
      load(16'h0001);
      `CHK("dblext", 16'h4001, ext)
      alau_mem_model_inst.words[1] = 16'h0002;
      alau_mem_model_inst.words[2] = 16'h4000;
      run_op(`ALAU_OP_ADD, 3'h0);
      `CHK("dbladd", 16'h0004, acc)
      `CHK("dbllow", 16'h0001, ext)
      `CHK("dblcy", 1'b0, cy)
      run_op(`ALAU_OP_STORE, 3'h0);
      `CHK("dblst", 1'b1, mwd)
      `CHK("dblsthi", 16'h0004, wd)
      `CHK("dblstlo", 16'h0001, wdl)
      run_op(`ALAU_OP_SGL, 3'h0);
      $display("normalize and keys test done");
      for (int k = 0; k < 5; k++) begin
         for (int c = 0; c < 8; c++) check_op(`ALAU_OP_LOGIC, c[2:0], corners[k], 16'h0000);
         for (int j = 0; j < 15; j++) check_op(ops[j], 3'h0, corners[k], corners[(k + j) % 5]);
      end
      $display("corner test done");
      for (int i = 0; i < 150; i++) begin
         seed = xs(seed);
         check_op(ops[seed[31:16] % 15], seed[2:0], seed[15:0], seed[31:16] ^ seed[23:8]);
      end
      $display("random test done");
      test_done();
   end
endmodule // alau_core_tb
